// ### swc_pkg.sv
// Purpose: shared constants and types for the standby wake-up sequencer
// Assumes: one clock at 10 MHz, synchronous active-high reset
// Notes: warm-up counts are powers of two of the oscillator-enable cycles
package swc_pkg;
   typedef enum logic [4:0] {
      SWC_RUN    = 5'h01,
      SWC_DOZE   = 5'h02,
      SWC_HALT   = 5'h04,
      SWC_STOP   = 5'h08,
      SWC_WARMUP = 5'h10
   } swc_state_t;

   // standby request codes from the core
   localparam logic [1:0] SWC_REQ_NONE = 2'h0;
   localparam logic [1:0] SWC_REQ_DOZE = 2'h1;
   localparam logic [1:0] SWC_REQ_HALT = 2'h2;
   localparam logic [1:0] SWC_REQ_STOP = 2'h3;

   // gateable peripherals in doze: adc, serial, i2c, timer a/b/c, watchdog, pulse counter
   localparam int SWC_NPERIPH = 8;
   localparam int SWC_MASK_W = 3;
   localparam int SWC_WSEL_W = 2;
   localparam int SWC_CNT_W = 17;
   // warm-up lengths 2^n oscillator cycles, indexed by warmup_time_select
   localparam logic [4:0] SWC_WUP_EXP0 = 5'h06;
   localparam logic [4:0] SWC_WUP_EXP1 = 5'h08;
   localparam logic [4:0] SWC_WUP_EXP2 = 5'h0e;
   localparam logic [4:0] SWC_WUP_EXP3 = 5'h10;

   // wake source bit positions
   localparam int SWC_SRC_NMI = 0;
   localparam int SWC_SRC_EXT = 1;
   localparam int SWC_SRC_KEY = 2;
   localparam int SWC_SRC_WDT = 3;
   localparam int SWC_SRC_TMR = 4;
   localparam int SWC_SRC_SIO = 5;
   localparam int SWC_SRC_I2C = 6;
   localparam int SWC_SRC_ADC = 7;
   localparam int SWC_NSRC = 8;
   localparam logic [SWC_NSRC-1:0] SWC_STOP_SRC_MASK = 8'h07;

   localparam logic [SWC_NSRC-1:0] SWC_SRC_ZERO = 8'h00;
   localparam logic [SWC_NPERIPH-1:0] SWC_PER_ZERO = 8'h00;
   localparam logic [SWC_NPERIPH-1:0] SWC_PER_ALL = 8'hff;
   localparam logic [SWC_CNT_W-1:0] SWC_CNT_ZERO = 17'h00000;
   localparam logic [SWC_CNT_W-1:0] SWC_CNT_ONE = 17'h00001;
endpackage : swc_pkg

// ### swc_if.sv
// Purpose: link between standby sequencer and core/interrupt-controller end
// Assumes: single clock domain
// Notes: requests are levels held until answered
`timescale 1ns/10ps
interface swc_if;
   logic [1:0] standby_req;
   logic [swc_pkg::SWC_NPERIPH-1:0] doze_periph_enable;
   logic [swc_pkg::SWC_WSEL_W-1:0] warmup_time_select;
   logic stop_pin_drive_enable;
   logic slow_mode;
   logic [swc_pkg::SWC_MASK_W-1:0] interrupt_mask_level;
   logic [swc_pkg::SWC_NSRC-1:0] wake_src;
   logic [swc_pkg::SWC_MASK_W-1:0] wake_level;
   logic standby_ack;
   logic wake_done;
   logic wake_service;
   logic resume_slow;

   modport seq (
      input standby_req, doze_periph_enable, warmup_time_select, stop_pin_drive_enable,
      input slow_mode, interrupt_mask_level, wake_src, wake_level,
      output standby_ack, wake_done, wake_service, resume_slow
   );
   modport core (
      output standby_req, doze_periph_enable, warmup_time_select, stop_pin_drive_enable,
      output slow_mode, interrupt_mask_level, wake_src, wake_level,
      input standby_ack, wake_done, wake_service, resume_slow
   );
endinterface : swc_if

// ### swc_core_end.sv
// Purpose: core and interrupt-controller end of the standby link
// Assumes: user side programs controls before asking for standby
// Notes: forwards only wake-up sources enabled by the user
`timescale 1ns/10ps
module swc_core_end (
   input wire logic clk,
   input wire logic reset,
   swc_if.core lnk,
   input wire logic [1:0] enter_req,
   input wire logic [swc_pkg::SWC_NPERIPH-1:0] periph_enable,
   input wire logic [swc_pkg::SWC_WSEL_W-1:0] warmup_sel,
   input wire logic pin_drive,
   input wire logic slow,
   input wire logic [swc_pkg::SWC_MASK_W-1:0] mask_level,
   input wire logic [swc_pkg::SWC_NSRC-1:0] irq_raw,
   input wire logic [swc_pkg::SWC_NSRC-1:0] irq_wake_en,
   input wire logic [swc_pkg::SWC_MASK_W-1:0] irq_level,
   output logic in_standby,
   output logic resumed,
   output logic run_handler,
   output logic pc_advance
);
   logic [1:0] req_q;
   logic in_standby_q;
   logic resumed_q;
   logic run_handler_q;
   logic pc_advance_q;
   logic [swc_pkg::SWC_NSRC-1:0] src_q;
   logic [swc_pkg::SWC_MASK_W-1:0] lvl_q;
   logic [swc_pkg::SWC_NPERIPH-1:0] pen_q;
   logic [swc_pkg::SWC_WSEL_W-1:0] wsel_q;
   logic drv_q;
   logic slow_q;
   logic [swc_pkg::SWC_MASK_W-1:0] mask_q;

   ////////////////////////////////////////////////////////////////////////////
   // controls latched before the standby request, frozen while asleep
   always_ff @(posedge clk) begin
      if (reset) begin
         pen_q <= swc_pkg::SWC_PER_ZERO;
         wsel_q <= 2'h3;
         drv_q <= 1'b0;
         slow_q <= 1'b0;
         mask_q <= 3'h0;
      end else if (!in_standby_q && req_q == swc_pkg::SWC_REQ_NONE) begin
         pen_q <= periph_enable;
         wsel_q <= (warmup_sel == 2'h1) ? 2'h2 : warmup_sel;
         drv_q <= pin_drive;
         slow_q <= slow;
         mask_q <= mask_level;
      end
   end

   // non-wake sources are blocked here so they cannot end standby
   always_ff @(posedge clk) begin
      if (reset) begin
         src_q <= swc_pkg::SWC_SRC_ZERO;
         lvl_q <= 3'h0;
      end else begin
         src_q <= irq_raw & irq_wake_en;
         lvl_q <= irq_level;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         req_q <= swc_pkg::SWC_REQ_NONE;
         in_standby_q <= 1'b0;
         resumed_q <= 1'b0;
         run_handler_q <= 1'b0;
         pc_advance_q <= 1'b0;
      end else begin
         resumed_q <= 1'b0;
         if (lnk.wake_done) begin
            req_q <= swc_pkg::SWC_REQ_NONE;
            in_standby_q <= 1'b0;
            resumed_q <= 1'b1;
            run_handler_q <= lnk.wake_service;
            pc_advance_q <= lnk.wake_service;
         // a held request must not starve the ack below
         end else if (!in_standby_q && req_q == swc_pkg::SWC_REQ_NONE &&
                      enter_req != swc_pkg::SWC_REQ_NONE) begin
            req_q <= enter_req;
         end else if (lnk.standby_ack) begin
            in_standby_q <= 1'b1;
         end
      end
   end

   assign lnk.standby_req = req_q;
   assign lnk.doze_periph_enable = pen_q;
   assign lnk.warmup_time_select = wsel_q;
   assign lnk.stop_pin_drive_enable = drv_q;
   assign lnk.slow_mode = slow_q;
   assign lnk.interrupt_mask_level = mask_q;
   assign lnk.wake_src = src_q;
   assign lnk.wake_level = lvl_q;
   assign in_standby = in_standby_q;
   assign resumed = resumed_q;
   assign run_handler = run_handler_q;
   assign pc_advance = pc_advance_q;
endmodule : swc_core_end

// ### swc_sequencer.sv
// Purpose: standby sequencer gating oscillator, pll, cpu and peripheral clocks
// Assumes: core end holds standby_req until wake_done
// Notes: ram retention is outside this block; reset simply clears it all
`timescale 1ns/10ps
// Contract
// - stop halts oscillator, pll, peripherals, cpu
// - idle keeps osc and pll, cpu gated
// - doze keeps dma, irq controller, bus, ports
// - doze peripherals individually enabled, else off
// - only interrupt or reset ends standby
// - wake depends on mode and mask
// - level at or above mask runs handler
// - below mask resumes at entry, pending
// - nmi always serviced
// - reset ends standby, clears state
// - interrupt wake keeps internal state
// - stop wakes only on nmi, ext, key
// - stop wake waits for warm-up timer
// - level interrupts held until serviced
// - software blocks non-wake interrupts first
// - stop pins follow drive enable bit
// - system clock restarts after warm-up
// - stop resumes previous normal or slow
// - controls programmed before standby entry
// - normal-to-stop avoids warm-up 00, 01; core end remaps 01 to 10, but 00 still runs as 64 cycles
// - halt ignores external bus requests
// - doze grants external bus requests
// - warm-up code 01 never used
module swc_sequencer (
   input wire logic clk,
   input wire logic reset,
   swc_if.seq lnk,
   input wire logic crystal_source,
   input wire logic ext_bus_req,
   output logic osc_enable,
   output logic pll_enable,
   output logic cpu_clk_enable,
   output logic sys_clk_out_enable,
   output logic [swc_pkg::SWC_NPERIPH-1:0] periph_clk_enable,
   output logic dma_clk_enable,
   output logic irq_ctrl_clk_enable,
   output logic bus_if_enable,
   output logic ports_enable,
   output logic ext_bus_grant,
   output logic pins_hold_drive,
   output logic slow_active
);
   swc_pkg::swc_state_t state_q;
   swc_pkg::swc_state_t state_d;
   logic [swc_pkg::SWC_CNT_W-1:0] wcnt_q;
   logic [swc_pkg::SWC_CNT_W-1:0] wlimit;
   logic [swc_pkg::SWC_NSRC-1:0] eligible;
   logic wake_any;
   logic service;
   logic ack_q;
   logic done_q;
   logic serv_q;
   logic slow_q;
   logic osc_q;
   logic pll_q;
   logic cpu_q;
   logic sys_q;
   logic [swc_pkg::SWC_NPERIPH-1:0] per_q;
   logic dma_q;
   logic irq_ctrl_q;
   logic bus_q;
   logic ports_q;
   logic grant_q;
   logic pins_q;

   ////////////////////////////////////////////////////////////////////////////
   // wake qualification
   always_comb begin
      eligible = lnk.wake_src;
      if (state_q == swc_pkg::SWC_STOP) begin
         eligible = lnk.wake_src & swc_pkg::SWC_STOP_SRC_MASK;
      end
      wake_any = |eligible;
      // nmi overrides the mask; others compare request level to mask level
      service = eligible[swc_pkg::SWC_SRC_NMI] ||
                (lnk.wake_level >= lnk.interrupt_mask_level);
   end

   always_comb begin
      case (lnk.warmup_time_select)
         2'h0: wlimit = swc_pkg::SWC_CNT_ONE << swc_pkg::SWC_WUP_EXP0;
         2'h1: wlimit = swc_pkg::SWC_CNT_ONE << swc_pkg::SWC_WUP_EXP1;
         2'h2: wlimit = swc_pkg::SWC_CNT_ONE << swc_pkg::SWC_WUP_EXP2;
         default: wlimit = swc_pkg::SWC_CNT_ONE << swc_pkg::SWC_WUP_EXP3;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode sequencing
   always_comb begin
      state_d = state_q;
      case (state_q)
         swc_pkg::SWC_RUN: begin
            // old request still shows while done is out; taking it would re-enter
            if (!done_q) begin
               case (lnk.standby_req)
                  swc_pkg::SWC_REQ_DOZE: state_d = swc_pkg::SWC_DOZE;
                  swc_pkg::SWC_REQ_HALT: state_d = swc_pkg::SWC_HALT;
                  swc_pkg::SWC_REQ_STOP: state_d = swc_pkg::SWC_STOP;
                  default: state_d = swc_pkg::SWC_RUN;
               endcase
            end
         end
         swc_pkg::SWC_DOZE, swc_pkg::SWC_HALT: begin
            if (wake_any) state_d = swc_pkg::SWC_RUN;
         end
         swc_pkg::SWC_STOP: begin
            if (wake_any) state_d = swc_pkg::SWC_WARMUP;
         end
         swc_pkg::SWC_WARMUP: begin
            if (wcnt_q >= wlimit - swc_pkg::SWC_CNT_ONE) state_d = swc_pkg::SWC_RUN;
         end
         default: state_d = swc_pkg::SWC_RUN;
      endcase
   end

   // only the state register moves; all else waits for the core
   always_ff @(posedge clk) begin
      if (reset) begin
         state_q <= swc_pkg::SWC_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // counts oscillator cycles since re-enable; also used in halt/doze never
   always_ff @(posedge clk) begin
      if (reset || state_q != swc_pkg::SWC_WARMUP) begin
         wcnt_q <= swc_pkg::SWC_CNT_ZERO;
      end else begin
         wcnt_q <= wcnt_q + swc_pkg::SWC_CNT_ONE;
      end
   end

   // handshake; service decision captured at the wake moment
   always_ff @(posedge clk) begin
      if (reset) begin
         ack_q <= 1'b0;
         done_q <= 1'b0;
         serv_q <= 1'b0;
         slow_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (state_q == swc_pkg::SWC_RUN && state_d != swc_pkg::SWC_RUN) begin
            ack_q <= 1'b1;
            slow_q <= lnk.slow_mode;
         end
         if (wake_any && (state_q == swc_pkg::SWC_DOZE || state_q == swc_pkg::SWC_HALT ||
                          state_q == swc_pkg::SWC_STOP)) begin
            serv_q <= service;
         end
         if (state_q != swc_pkg::SWC_RUN && state_d == swc_pkg::SWC_RUN) begin
            ack_q <= 1'b0;
            done_q <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // clock and block gating, registered from the next state
   always_ff @(posedge clk) begin
      if (reset) begin
         osc_q <= 1'b0;
         pll_q <= 1'b1;
         cpu_q <= 1'b1;
         sys_q <= 1'b1;
         per_q <= swc_pkg::SWC_PER_ALL;
         dma_q <= 1'b1;
         irq_ctrl_q <= 1'b1;
         bus_q <= 1'b1;
         ports_q <= 1'b1;
         grant_q <= 1'b0;
         pins_q <= 1'b0;
      end else begin
         osc_q <= crystal_source;
         pll_q <= 1'b1;
         cpu_q <= 1'b0;
         sys_q <= 1'b1;
         per_q <= swc_pkg::SWC_PER_ZERO;
         dma_q <= 1'b0;
         irq_ctrl_q <= 1'b1;
         bus_q <= 1'b0;
         ports_q <= 1'b0;
         grant_q <= 1'b0;
         pins_q <= 1'b0;
         case (state_d)
            swc_pkg::SWC_RUN: begin
               cpu_q <= 1'b1;
               per_q <= swc_pkg::SWC_PER_ALL;
               dma_q <= 1'b1;
               bus_q <= 1'b1;
               ports_q <= 1'b1;
               grant_q <= ext_bus_req;
            end
            swc_pkg::SWC_DOZE: begin
               per_q <= lnk.doze_periph_enable;
               dma_q <= 1'b1;
               bus_q <= 1'b1;
               ports_q <= 1'b1;
               grant_q <= ext_bus_req;
            end
            swc_pkg::SWC_HALT: begin
               grant_q <= 1'b0;
            end
            swc_pkg::SWC_STOP: begin
               osc_q <= 1'b0;
               pll_q <= 1'b0;
               sys_q <= 1'b0;
               irq_ctrl_q <= 1'b0;
               pins_q <= lnk.stop_pin_drive_enable;
            end
            swc_pkg::SWC_WARMUP: begin
               // oscillator enable follows crystal_source again, everything else waits for stability
               pll_q <= 1'b0;
               sys_q <= 1'b0;
               irq_ctrl_q <= 1'b0;
               pins_q <= lnk.stop_pin_drive_enable;
            end
            default: begin
               cpu_q <= 1'b1;
            end
         endcase
      end
   end

   assign lnk.standby_ack = ack_q;
   assign lnk.wake_done = done_q;
   assign lnk.wake_service = serv_q;
   assign lnk.resume_slow = slow_q;
   assign osc_enable = osc_q;
   assign pll_enable = pll_q;
   assign cpu_clk_enable = cpu_q;
   assign sys_clk_out_enable = sys_q;
   assign periph_clk_enable = per_q;
   assign dma_clk_enable = dma_q;
   assign irq_ctrl_clk_enable = irq_ctrl_q;
   assign bus_if_enable = bus_q;
   assign ports_enable = ports_q;
   assign ext_bus_grant = grant_q;
   assign pins_hold_drive = pins_q;
   assign slow_active = slow_q;
endmodule : swc_sequencer

// ### swc_sva.sv
// Purpose: link checks between the standby sequencer and the core end
// Assumes: one clock, synchronous active-high reset
// Notes: sees only the link signals
`timescale 1ns/10ps
module swc_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic [1:0] standby_req,
   input wire logic [1:0] warmup_time_select,
   input wire logic slow_mode,
   input wire logic [2:0] interrupt_mask_level,
   input wire logic [7:0] wake_src,
   input wire logic [2:0] wake_level,
   input wire logic standby_ack,
   input wire logic wake_done,
   input wire logic wake_service,
   input wire logic resume_slow
);
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   logic [17:0] warm_q;
   logic [17:0] warm_len;
   logic stop_w;
   ////////////////////////////////////////
   // 01 taken as 10, since the core end remaps it
   assign warm_len = 18'h1 << ((warmup_time_select == 2'h0) ? swc_pkg::SWC_WUP_EXP0 :
      (warmup_time_select == 2'h3) ? swc_pkg::SWC_WUP_EXP3 : swc_pkg::SWC_WUP_EXP2);
   assign stop_w = wake_done && standby_req == swc_pkg::SWC_REQ_STOP;
   // counts only once a stop-capable source shows
   always_ff @(posedge clk) begin
      if (reset || !standby_ack) begin
         warm_q <= 18'h0;
      end else if (warm_q != 18'h0 || (standby_req == swc_pkg::SWC_REQ_STOP &&
            (wake_src & swc_pkg::SWC_STOP_SRC_MASK) != 8'h00)) begin
         warm_q <= warm_q + 18'h1;
      end
   end
   ////////////////////////////////////////
   a_ack_on_req: assert property (standby_req != 2'h0 && $past(standby_req) == 2'h0 &&
      !standby_ack |=> standby_ack) else $error("no ack after request");
   a_ack_until_done: assert property ($fell(standby_ack) |-> wake_done)
      else $error("ack fell without wake");
   a_done_needs_ack: assert property (wake_done |-> $past(standby_ack))
      else $error("wake without standby");
   a_done_one_cycle: assert property (wake_done |=> !wake_done)
      else $error("wake pulse too long");
   a_idle_service_level: assert property (wake_done && standby_req != swc_pkg::SWC_REQ_STOP
      |-> wake_service == ($past(wake_src[0]) || $past(wake_level) >= $past(interrupt_mask_level)))
      else $error("service decision wrong");
   a_nmi_always_served: assert property (wake_done && $past(wake_src[0]) |-> wake_service)
      else $error("nmi not served");
   a_stop_source_only: assert property (stop_w |-> warm_q != 18'h0)
      else $error("stop left without stop source");
   a_warmup_length: assert property (stop_w |-> warm_q + 18'h1 >= warm_len &&
      warm_q <= warm_len + 18'h2) else $error("warm-up length wrong");
   a_stop_resume_mode: assert property (stop_w |-> resume_slow == slow_mode)
      else $error("resume mode wrong");
   c_served: cover property (wake_done && wake_service);
   c_pending: cover property (wake_done && !wake_service);
   c_stop_wake: cover property (stop_w);
endmodule : swc_sva

// ### test_standby_wakeup_control.sv
// Purpose: self-checking bench joining both ends of the standby link
// Assumes: inputs driven at the falling edge
// Notes: stop runs use real warm-up counts, so the run is long
`timescale 1ns/10ps
module test_standby_wakeup_control;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic [1:0] enter_req = 2'h0;
   logic [7:0] pe = 8'h00;
   logic [1:0] wsel = 2'h0;
   logic pin_drive = 1'b0;
   logic slow = 1'b0;
   logic [2:0] mask = 3'h0;
   logic [7:0] irq_raw = 8'h00;
   logic [2:0] irq_level = 3'h0;
   logic crystal = 1'b1;
   logic ext_req = 1'b0;
   logic in_standby, resumed, run_handler, pc_advance, osc, pll, cpu, sysclk;
   logic dma, irq_ctrl, busif, ports, grant, pins, slow_act;
   logic [7:0] per;
   logic [1:0] exp_q[$];
   logic [15:0] seed = 16'hb728;
   int failures = 0;
   int checks = 0;
   swc_if u_swc_if();
   swc_sequencer u_swc_sequencer (.clk(clk), .reset(reset), .lnk(u_swc_if),
      .crystal_source(crystal), .ext_bus_req(ext_req), .osc_enable(osc), .pll_enable(pll),
      .cpu_clk_enable(cpu), .sys_clk_out_enable(sysclk), .periph_clk_enable(per),
      .dma_clk_enable(dma), .irq_ctrl_clk_enable(irq_ctrl), .bus_if_enable(busif),
      .ports_enable(ports), .ext_bus_grant(grant), .pins_hold_drive(pins),
      .slow_active(slow_act));
   swc_core_end u_swc_core_end (.clk(clk), .reset(reset), .lnk(u_swc_if),
      .enter_req(enter_req), .periph_enable(pe), .warmup_sel(wsel), .pin_drive(pin_drive),
      .slow(slow), .mask_level(mask), .irq_raw(irq_raw), .irq_wake_en(8'hff),
      .irq_level(irq_level), .in_standby(in_standby), .resumed(resumed),
      .run_handler(run_handler), .pc_advance(pc_advance));
   swc_sva u_swc_sva (.clk(clk), .reset(reset), .standby_req(u_swc_if.standby_req),
      .warmup_time_select(u_swc_if.warmup_time_select), .slow_mode(u_swc_if.slow_mode),
      .interrupt_mask_level(u_swc_if.interrupt_mask_level), .wake_src(u_swc_if.wake_src),
      .wake_level(u_swc_if.wake_level), .standby_ack(u_swc_if.standby_ack),
      .wake_done(u_swc_if.wake_done), .wake_service(u_swc_if.wake_service),
      .resume_slow(u_swc_if.resume_slow));
   ////////////////////////////////////////
   initial begin
      forever #50 clk = ~clk;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic finish_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : finish_test
   task automatic guard(input int n, input int lim);
      if (n >= lim) begin
         failures++;
         finish_test();
      end
   endtask : guard
   ////////////////////////////////////////
   task automatic run(input logic [1:0] md, input int src, input logic [1:0] ws,
         input logic sl);
      logic stp;
      logic svc;
      int n;
      seed = lfsr(seed);
      stp = md == swc_pkg::SWC_REQ_STOP;
      @(negedge clk);
      pe = seed[15:8];
      wsel = ws;
      slow = sl;
      mask = (src == 0) ? 3'h7 : seed[5:3];
      irq_level = (src == 0) ? 3'h0 : seed[2:0];
      pin_drive = seed[6];
      crystal = seed[7];
      ext_req = seed[8];
      enter_req = md;
      n = 0;
      while (in_standby !== 1'b1 && n < 20) begin
         @(negedge clk);
         n++;
      end
      guard(n, 20);
      enter_req = 2'h0;
      check(cpu, 0);
      check(osc, stp ? 1'b0 : crystal);
      check(pll, !stp);
      check(irq_ctrl, !stp);
      check({dma, busif, ports, grant}, (md == swc_pkg::SWC_REQ_DOZE) ? {3'h7, ext_req} : 4'h0);
      check(per, (md == swc_pkg::SWC_REQ_DOZE) ? pe : 8'h00);
      if (stp) begin
         check(pins, pin_drive);
         // idle-only sources must not end stop
         irq_raw = 8'hf8;
         repeat (100) @(negedge clk);
         check(in_standby, 1);
      end
      irq_raw = 8'h01 << src;
      svc = src == 0 || irq_level >= mask;
      exp_q.push_back({svc, svc});
      n = 0;
      while (resumed !== 1'b1 && n < 70000) begin
         @(negedge clk);
         n++;
      end
      guard(n, 70000);
      irq_raw = 8'h00;
      if (stp) check(n >= ((ws == 2'h0) ? 64 : (ws == 2'h3) ? 65536 : 16384), 1);
      if (stp) check(slow_act, sl);
      check({cpu, sysclk, pll}, 3'h7);
      $display("test mode %0d source %0d done", md, src);
   endtask : run
   ////////////////////////////////////////
   always @(negedge clk) begin
      if (resumed === 1'b1) begin
         if (exp_q.size() != 0) check({run_handler, pc_advance}, exp_q.pop_front());
         else check(1, 0);
      end
   end
   initial begin
      repeat (10) @(negedge clk);
      reset = 1'b0;
      run(swc_pkg::SWC_REQ_DOZE, swc_pkg::SWC_SRC_TMR, 2'h0, 1'b0);
      run(swc_pkg::SWC_REQ_HALT, swc_pkg::SWC_SRC_ADC, 2'h0, 1'b0);
      run(swc_pkg::SWC_REQ_DOZE, swc_pkg::SWC_SRC_NMI, 2'h0, 1'b0);
      run(swc_pkg::SWC_REQ_HALT, swc_pkg::SWC_SRC_SIO, 2'h0, 1'b0);
      run(swc_pkg::SWC_REQ_STOP, swc_pkg::SWC_SRC_EXT, 2'h0, 1'b1);
      run(swc_pkg::SWC_REQ_STOP, swc_pkg::SWC_SRC_KEY, 2'h1, 1'b0);
      run(swc_pkg::SWC_REQ_STOP, swc_pkg::SWC_SRC_NMI, 2'h3, 1'b1);
      // reset in the middle of halt
      enter_req = swc_pkg::SWC_REQ_HALT;
      repeat (6) @(negedge clk);
      enter_req = 2'h0;
      check(in_standby, 1);
      reset = 1'b1;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      @(negedge clk);
      check({in_standby, cpu}, 2'h1);
      $display("test reset in standby done");
      finish_test();
   end
endmodule : test_standby_wakeup_control
